// *** include/pdps_pkg.sv ***
// Package for the PLL dynamic phase shift control block
package pdps_pkg;
    // Counter select width and default shift busy time
    localparam int          SEL_WIDTH       = 3;
    localparam int          BUSY_CNT_WIDTH  = 8;
    localparam logic [7:0]  SHIFT_BUSY_CYC  = 8'h03;
    localparam logic        COMPLETE_RST    = 1'b1;
    localparam logic        DIR_RST         = 1'b0;

    // Shift parameters captured at the second rising edge
    typedef struct packed {
        logic                 up;
        logic [SEL_WIDTH-1:0] sel;
    } pdps_shift_t;

    typedef enum logic [1:0] {
        PDPS_IDLE,
        PDPS_WAIT,
        PDPS_SHIFT
    } pdps_state_t;
endpackage

// *** hw/pdps_ctrl.sv ***
// PLL dynamic phase shift step handshake, device end
`timescale 1ns/10ps

module pdps_ctrl #(
    parameter int                 SEL_WIDTH  = pdps_pkg::SEL_WIDTH,
    parameter logic [7:0]         BUSY_CYC   = pdps_pkg::SHIFT_BUSY_CYC
) (
    // Clock (the reconfiguration clock), reset and enable
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    // Request side from fabric controller
    input  wire logic                 shift_pulse_req,
    input  wire logic                 shift_direction,
    input  wire logic [SEL_WIDTH-1:0] shift_counter_sel,
    output logic                      shift_complete,
    // Toward the PLL counters
    output logic [SEL_WIDTH-1:0]      pll_counter_sel,
    output logic                      pll_shift_up,
    output logic                      pll_shift_busy,
    output logic                      pll_step_start
);

    ////////////////////////////////////////////////////////////////////////////
    pdps_pkg::pdps_state_t      state_reg;
    pdps_pkg::pdps_state_t      state_next;
    logic                       req_fall_reg;
    logic                       armed_reg;
    logic                       armed_next;
    logic [7:0]                 busy_cnt_reg;
    logic [7:0]                 busy_cnt_next;
    logic                       complete_reg;
    logic                       complete_next;
    logic                       start_reg;
    logic                       up_reg;
    logic [SEL_WIDTH-1:0]       sel_reg;
    wire                        take_req;
    wire                        capture;
    wire                        busy_done;
    wire                        in_idle;
    wire                        in_wait;
    wire                        in_shift;
    wire                        rearm;
    wire  [7:0]                 busy_load;
    wire                        start_next;
    wire                        busy_next;
    logic                       busy_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Falling-edge sample keeps the request off the rising edge that captures
    always_ff @(negedge sys_clk or posedge rst)
    begin
        if (rst)
            req_fall_reg <= 1'b0;
        else if (ce)
            req_fall_reg <= shift_pulse_req;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Re-arming only on a low sample means a long pulse gives one step
    assign in_idle    = (state_reg == pdps_pkg::PDPS_IDLE);
    assign in_wait    = (state_reg == pdps_pkg::PDPS_WAIT);
    assign in_shift   = (state_reg == pdps_pkg::PDPS_SHIFT);
    assign rearm      = !req_fall_reg;
    assign take_req   = in_idle && req_fall_reg && armed_reg;
    assign capture    = in_wait;
    assign busy_done  = in_shift && (busy_cnt_reg == 8'h00);
    assign busy_load  = BUSY_CYC - 8'h01;
    assign start_next = capture;
    assign busy_next  = ~complete_next;

    always_comb
    begin
        state_next    = state_reg;
        armed_next    = armed_reg;
        busy_cnt_next = busy_cnt_reg;
        complete_next = complete_reg;
        if (rearm)
            armed_next = 1'b1;
        case (state_reg)
            pdps_pkg::PDPS_IDLE:
            begin
                if (take_req)
                begin
                    state_next = pdps_pkg::PDPS_WAIT;
                    armed_next = 1'b0;
                end
            end
            pdps_pkg::PDPS_WAIT:
            begin
                state_next    = pdps_pkg::PDPS_SHIFT;
                complete_next = 1'b0;
                busy_cnt_next = busy_load;
            end
            pdps_pkg::PDPS_SHIFT:
            begin
                // Busy time is a parameter since it tracks VCO speed
                if (busy_done)
                begin
                    state_next    = pdps_pkg::PDPS_IDLE;
                    complete_next = 1'b1;
                end
                else
                    busy_cnt_next = busy_cnt_reg - 8'h01;
            end
            default:
            begin
                state_next    = pdps_pkg::PDPS_IDLE;
                complete_next = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= pdps_pkg::PDPS_IDLE;
        end
        else if (ce)
        begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            armed_reg <= 1'b1;
        end
        else if (ce)
        begin
            armed_reg <= armed_next;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            busy_cnt_reg <= 8'h00;
        end
        else if (ce)
        begin
            busy_cnt_reg <= busy_cnt_next;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            complete_reg <= pdps_pkg::COMPLETE_RST;
        end
        else if (ce)
        begin
            complete_reg <= complete_next;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            start_reg <= 1'b0;
        end
        else if (ce)
        begin
            start_reg <= start_next;
        end
    end

    // Own flop so the busy pin has no gate after the register
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            busy_reg <= 1'b0;
        end
        else if (ce)
        begin
            busy_reg <= busy_next;
        end
    end

    // Captured parameters; the controller keeps them stable until here
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            up_reg <= pdps_pkg::DIR_RST;
        end
        else if (ce && capture)
        begin
            up_reg <= shift_direction;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            sel_reg <= '0;
        end
        else if (ce && capture)
        begin
            sel_reg <= shift_counter_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign shift_complete  = complete_reg;
    assign pll_counter_sel = sel_reg;
    assign pll_shift_up    = up_reg;
    assign pll_shift_busy  = busy_reg;
    assign pll_step_start  = start_reg;

endmodule

// *** verification/pdps_chk.sv ***
// Port assertions for the phase shift handshake
`timescale 1ns/10ps
module pdps_chk #(parameter int BUSY_CYC = 3) (
    // Watched ports
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic       shift_pulse_req,
    input wire logic [2:0] shift_counter_sel,
    input wire logic       shift_complete,
    input wire logic [2:0] pll_counter_sel,
    input wire logic       pll_shift_busy,
    input wire logic       pll_step_start
);
    localparam int L = BUSY_CYC - 1;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_req_to_fall: assert property ($rose(shift_pulse_req) && shift_complete |->
        ##1 shift_complete ##1 !shift_complete) else $error("late fall");
    a_sel_capture: assert property ($fell(shift_complete) |->
        pll_counter_sel == $past(shift_counter_sel)) else $error("bad select");
    a_start_pulse: assert property ($fell(shift_complete) |->
        pll_step_start ##1 !pll_step_start) else $error("bad start");
    a_low_time: assert property ($fell(shift_complete) |->
        (!shift_complete throughout (##L 1'b1)) ##1 shift_complete) else $error("low time");
    a_start_single: assert property (pll_step_start |=> !pll_step_start)
        else $error("start too long");
    a_start_busy: assert property (pll_step_start |-> pll_shift_busy)
        else $error("start while idle");
    a_busy_mirror: assert property (pll_shift_busy != shift_complete)
        else $error("busy mismatch");
endmodule

// *** verification/pdps_host.sv ***
// Fabric controller model issuing step requests
`timescale 1ns/10ps
module pdps_host (
    // Bench and block side
    input wire logic       sys_clk,
    input wire logic       go,
    input wire logic [3:0] cmd,
    input wire logic       shift_complete,
    output logic           shift_pulse_req,
    output logic           shift_direction,
    output logic [2:0]     shift_counter_sel
);
    initial
    begin
        {shift_pulse_req, shift_direction, shift_counter_sel} = 5'h00;
        forever
        begin
            @(posedge sys_clk);
            if (go)
            begin
                #1 {shift_direction, shift_counter_sel} = cmd;
                shift_pulse_req = 1'b1;
                @(negedge shift_complete);
                @(posedge sys_clk);
                // Released lines show garbage, not the last value
                #1 {shift_direction, shift_counter_sel} = ~cmd;
                shift_pulse_req = 1'b0;
                @(posedge shift_complete);
            end
        end
    end
endmodule

// *** verification/tb.sv ***
// Self-checking bench for the phase shift handshake
`timescale 1ns/10ps
module tb;
    logic       sys_clk, rst, go, req, dir, done, up, busy, start;
    logic [2:0] sel, psel;
    logic [3:0] cmd, exp_q[$];
    int         seed, mismatches, cmp_count, cyc, n, f, k;
    pdps_ctrl #(.BUSY_CYC(8'h03)) dut_u (.sys_clk(sys_clk), .rst(rst), .ce(1'b1),
        .shift_pulse_req(req), .shift_direction(dir), .shift_counter_sel(sel),
        .shift_complete(done), .pll_counter_sel(psel), .pll_shift_up(up),
        .pll_shift_busy(busy), .pll_step_start(start));
    pdps_host host_u (.sys_clk(sys_clk), .go(go), .cmd(cmd), .shift_complete(done),
        .shift_pulse_req(req), .shift_direction(dir), .shift_counter_sel(sel));
    task automatic chk(input logic [3:0] seen, input logic [3:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            mismatches++;
            $display("BAD %0t seen %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish;
        if (mismatches == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 3000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // One capture per request, in issue order
    always @(negedge done)
    begin
        @(negedge sys_clk);
        f++;
        chk({up, psel}, exp_q.pop_front());
        chk({3'h0, start}, 4'h1);
        chk({3'h0, busy}, 4'h1);
        for (k = 0; done !== 1'b1; k++)
            @(negedge sys_clk);
        chk(4'(k), 4'(pdps_pkg::SHIFT_BUSY_CYC));
    end
    initial
    begin
        seed = 32'h7DB9C298;
        {rst, go, cmd} = 6'h20;
        repeat (10) @(posedge sys_clk);
        #1 rst = 1'b0;
        repeat (40)
        begin
            @(posedge sys_clk);
            #1 cmd = 4'($random(seed));
            go = 1'b1;
            exp_q.push_back(cmd);
            n++;
            @(posedge req);
            go = 1'b0;
            @(posedge done);
            // Idle gap varies with the random command
            repeat (cmd[1:0]) @(posedge sys_clk);
        end
        repeat (5) @(posedge sys_clk);
        chk(4'(f), 4'(n));
        tally_and_finish();
    end
endmodule
bind pdps_ctrl pdps_chk #(.BUSY_CYC(BUSY_CYC)) chk_u (.sys_clk(sys_clk), .rst(rst),
    .shift_pulse_req(shift_pulse_req), .shift_counter_sel(shift_counter_sel),
    .shift_complete(shift_complete), .pll_counter_sel(pll_counter_sel),
    .pll_shift_busy(pll_shift_busy), .pll_step_start(pll_step_start));
